/* File: rtl/dma_interrupt_status_reg.sv */
// Interrupt source status, latched flags, enables and the AHB-Lite slave.
// Assumes source levels are synchronous to ref_clk and a single AHB master.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// Operation
// RULE_01: Each implemented status bit is one while its source is present, zero at reset.
// RULE_02: A rising status bit sets the matching sticky flag bit.
// RULE_03: A status bit falls as soon as its source goes away.
// RULE_04: Flags stay set after status falls until software clears them.
// RULE_05: Status register is a 32-bit read-only word at offset 0x38.
// RULE_06: Software reads the flag register to see transient conditions that occurred.
// RULE_07: Bit 10 reports end of packet on the incoming stream.
// RULE_08: Bit 9 reports all writes of one write request completed.
// RULE_09: Bit 8 reports input buffer almost full, live.
// RULE_10: Bit 6 reports a requested abort has finished.
// RULE_11: Bit 5 is high while waiting for the advance signal after reset.
// RULE_12: Bit 4 reports a descriptor started executing after reset.
// RULE_13: Bit 3 reports chain end, only when the descriptor's chain-end enable is one.
// RULE_14: Bit 2 reports descriptor end, only when its descriptor-end enable is one.
// RULE_15: Bits 1 and 0 are read-only test bits reset to zero.
// RULE_16: Software clears a flag by writing one to its bit at offset 0x3C.
// RULE_17: Flags latch regardless of the interrupt enables.
// RULE_18: Bits 31 to 11 and 7 read zero; status writes do nothing.
module dma_interrupt_status_reg
  import irq_status_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Interrupt sources
  input  wire irq_src_type src,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Interrupt request
  output logic             irq
);

  irq_state_type state;
  irq_state_type next_state;
  logic [10:0]   liveSrc;
  logic [10:0]   rising;
  logic [10:0]   clearMask;
  logic          addrValid;

  // Map raw conditions onto the status layout
  always_comb begin
    liveSrc                 = '0;
    liveSrc[BIT_EOP]        = src.eopReached;                       // RULE_07
    liveSrc[BIT_ALL_WR]     = src.allWritesDone;                    // RULE_08
    liveSrc[BIT_IN_AFULL]   = src.inBufAlmostFull;                  // RULE_09
    liveSrc[BIT_ABORT]      = src.abortDone;                        // RULE_10
    liveSrc[BIT_WAIT_ADV]   = src.waitingAdvance;                   // RULE_11
    liveSrc[BIT_DESC_START] = src.descStart;                        // RULE_12
    liveSrc[BIT_CHAIN_END]  = src.chainEnd & src.chainEndIntEn;     // RULE_13
    liveSrc[BIT_DESC_END]   = src.descEnd & src.descEndIntEn;       // RULE_14
    liveSrc[BIT_TEST1]      = src.testChainEnd;                     // RULE_15
    liveSrc[BIT_TEST0]      = src.testDescEnd;                      // RULE_15
  end

  // Address phase accepted when selected, bus ready and htrans NONSEQ or SEQ
  assign addrValid = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  // Rising edges and software clear strobe
  always_comb begin
    rising    = liveSrc & ~state.status & SRC_MASK;                  // RULE_02
    clearMask = '0;
    // Write-one-to-clear lands on the flag register itself
    if (state.dataPhase && state.dataWrite && state.dataAddr == FLAG_OFFSET) begin
      clearMask = hwdata[SRC_BITS-1:0];                              // RULE_16
    end
  end

  // Next-state logic
  always_comb begin
    next_state        = state;
    next_state.status = liveSrc & SRC_MASK;                          // RULE_03
    // Set wins over clear; enables play no part here
    next_state.flags  = (state.flags & ~clearMask) | rising;         // RULE_04 RULE_17
    if (state.dataPhase && state.dataWrite && state.dataAddr == ENABLE_OFFSET) begin
      next_state.enables = hwdata[SRC_BITS-1:0] & SRC_MASK;
    end
    next_state.dataPhase = addrValid;
    if (addrValid) begin
      next_state.dataWrite = hwrite;
      next_state.dataAddr  = haddr[ADDR_BITS-1:0];
      next_state.readData  = READ_ZERO;                              // RULE_18
      if (!hwrite) begin
        unique case (haddr[ADDR_BITS-1:0])
          STATUS_OFFSET: next_state.readData = {21'h000000, liveSrc & SRC_MASK}; // RULE_05
          ENABLE_OFFSET: next_state.readData = {21'h000000, state.enables};
          FLAG_OFFSET:   next_state.readData = {21'h000000, next_state.flags};   // RULE_06
          default:       next_state.readData = READ_ZERO;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state         <= '0;
      state.status  <= SRC_RESET;                                    // RULE_01
      state.flags   <= SRC_RESET;
      state.enables <= SRC_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Bus answers and interrupt output
  assign hreadyout = 1'b1;                        // Zero wait states
  assign hresp     = 1'b0;                        // Always OKAY
  assign hrdata    = state.readData;
  assign irq       = |(state.flags & state.enables);

endmodule // dma_interrupt_status_reg

`default_nettype wire

/* File: rtl/irq_status_pkg.sv */
// Package for the DMA interrupt source status block.
// Assumes a single 250 MHz clock domain shared with the surrounding engine.
package irq_status_pkg;

  // Register byte offsets
  localparam logic [7:0]  STATUS_OFFSET = 8'h38;
  localparam logic [7:0]  ENABLE_OFFSET = 8'h34;
  localparam logic [7:0]  FLAG_OFFSET   = 8'h3C;
  localparam logic [7:0]  CLEAR_OFFSET  = 8'h40;
  localparam int          ADDR_BITS     = 8;

  // Field positions
  localparam int BIT_EOP        = 10;
  localparam int BIT_ALL_WR     = 9;
  localparam int BIT_IN_AFULL   = 8;
  localparam int BIT_ABORT      = 6;
  localparam int BIT_WAIT_ADV   = 5;
  localparam int BIT_DESC_START = 4;
  localparam int BIT_CHAIN_END  = 3;
  localparam int BIT_DESC_END   = 2;
  localparam int BIT_TEST1      = 1;
  localparam int BIT_TEST0      = 0;
  localparam int SRC_BITS       = 11;

  // Implemented bits of the status layout (bit 7 reserved)
  localparam logic [10:0] SRC_MASK      = 11'h77F;
  localparam logic [10:0] SRC_RESET     = 11'h000;
  localparam logic [31:0] READ_ZERO     = 32'h0000_0000;

  // AHB-Lite encodings
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;

  // Raw interrupt source conditions from the DMA engine
  typedef struct packed {
    logic eopReached;
    logic allWritesDone;
    logic inBufAlmostFull;
    logic abortDone;
    logic waitingAdvance;
    logic descStart;
    logic chainEnd;
    logic descEnd;
    logic chainEndIntEn;
    logic descEndIntEn;
    logic testChainEnd;
    logic testDescEnd;
  } irq_src_type;

  // Whole state of the block
  typedef struct packed {
    logic [10:0]          status;
    logic [10:0]          flags;
    logic [10:0]          enables;
    logic                 dataPhase;
    logic                 dataWrite;
    logic [ADDR_BITS-1:0] dataAddr;
    logic [31:0]          readData;
  } irq_state_type;

endpackage : irq_status_pkg

/* File: sim/dma_irq_monitor.sv */
// Checker of the status block: bus answers, status reads and flag latching.
// Sees the top module's ports only; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module dma_irq_monitor
  import irq_status_pkg::*;
(
  // Clock, reset and sources
  input wire logic        ref_clk, rst_n,
  input wire irq_src_type src,
  // Bus and interrupt
  input wire logic        hsel, hwrite, hready, hreadyout, hresp, irq,
  input wire logic [1:0]  htrans,
  input wire logic [31:0] haddr, hrdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Accepted NONSEQ reads of status and flags
  wire rd  = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
  wire rdS = rd && haddr[7:0] == STATUS_OFFSET;
  wire rdF = rd && haddr[7:0] == FLAG_OFFSET;
  // Status word from the source levels
  function automatic logic [31:0] stat(input irq_src_type s);
    return {21'h0, s.eopReached, s.allWritesDone, s.inBufAlmostFull, 1'b0, s.abortDone,
      s.waitingAdvance, s.descStart, s.chainEnd & s.chainEndIntEn,
      s.descEnd & s.descEndIntEn, s.testChainEnd, s.testDescEnd};
  endfunction
  AST_READY: assert property (hreadyout) else $error("wait state");
  AST_OKAY: assert property (!hresp) else $error("error response");
  AST_STATUS: assert property (rdS |=> hrdata == stat($past(src))) else $error("status");
  AST_RSVD: assert property (rd |=> (hrdata & 32'hFFFF_F880) == 0) else $error("rsvd");
  AST_CHAIN: assert property (rdS && !src.chainEndIntEn |=> !hrdata[3]) else $error("b3");
  AST_DESC: assert property (rdS && !src.descEndIntEn |=> !hrdata[2]) else $error("b2");
  AST_FALL: assert property (rdS && $fell(src.abortDone) |=> !hrdata[6]) else $error("b6");
  AST_RISE: assert property (rdF && $rose(src.eopReached) |=> hrdata[10]) else $error("f");
endmodule // dma_irq_monitor
bind dma_interrupt_status_reg dma_irq_monitor i_dma_irq_monitor (.*);
`default_nettype wire

/* File: sim/dma_interrupt_status_reg_test.sv */
// Bench of the status block: random sources, bus reads against a flag model.
// Drives the AHB-Lite slave alone; hready loops back from hreadyout.
`timescale 1ns/100ps
`default_nettype none
module dma_interrupt_status_reg_test
  import irq_status_pkg::*;
;
  logic        ref_clk = 0, rst_n = 0, hsel = 0, hwrite = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, d, r = 32'h407E, mf = 0, ps = 0, men = 0;
  irq_src_type src = 0;
  wire         hreadyout, hresp, irq;
  wire [31:0]  hrdata;
  int          bad_count = 0, comparisons = 0, cyc = 0;
  dma_interrupt_status_reg i_dma_interrupt_status_reg (.ref_clk(ref_clk), .rst_n(rst_n),
    .src(src), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq(irq));
  initial forever #2 ref_clk = ~ref_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Expected status word
  function automatic logic [31:0] smap(input irq_src_type s);
    return {21'h0, s.eopReached, s.allWritesDone, s.inBufAlmostFull, 1'b0, s.abortDone,
      s.waitingAdvance, s.descStart, s.chainEnd & s.chainEndIntEn,
      s.descEnd & s.descEndIntEn, s.testChainEnd, s.testDescEnd};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One single AHB-Lite transfer; read data taken at the closing edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] v,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic report_and_stop;
    $display("Mismatches %0d, comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Flag model: a rising status bit latches until cleared
  always @(posedge ref_clk) if (rst_n) begin
    mf = mf | (smap(src) & ~ps);
    ps = smap(src);
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 40; i++) begin
      r = lfsr(r);
      src <= r[11:0];
      ahb(1'b0, FLAG_OFFSET, 32'h0, d);
      chk(d, mf);
      ahb(1'b1, STATUS_OFFSET, r, d);
      ahb(1'b0, STATUS_OFFSET, 32'h0, d);
      chk(d, smap(src));
      men = r & 32'h77F;
      ahb(1'b1, ENABLE_OFFSET, r, d);
      ahb(1'b0, ENABLE_OFFSET, 32'h0, d);
      chk(d, men);
      chk({31'h0, irq}, {31'h0, |(mf & men)});
      ahb(1'b1, FLAG_OFFSET, r >> 3, d);
      mf &= ~(r >> 3);
      ahb(1'b0, 8'h50, 32'h0, d);
      chk(d, 32'h0);
      chk({31'h0, irq}, {31'h0, |(mf & men)});
    end
    report_and_stop();
  end
endmodule // dma_interrupt_status_reg_test
`default_nettype wire
